// [include/dmi_regs.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef DMI_REGS_SVH
`define DMI_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DMI_OFS_FUNC_LO 8'h00
`define DMI_OFS_FUNC_HI 8'h04
`define DMI_OFS_CTRL    8'h08
`define DMI_OFS_MAXFREQ 8'h0C
`define DMI_OFS_LIMITS  8'h10
`define DMI_OFS_JOGREF  8'h14
`define DMI_OFS_TRIM    8'h18
`define DMI_OFS_TIMER   8'h1C
`define DMI_OFS_HOLD    8'h20
`define DMI_OFS_STATUS  8'h24
`define DMI_OFS_FREQ    8'h28

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define DMI_CTRL_REFSEL    0
`define DMI_CTRL_HOLDMEM   1
`define DMI_CTRL_STOPCOAST 2
`define DMI_CTRL_UPLIMUSE  3
`define DMI_CTRL_SECFN_LSB 8
`define DMI_CTRL_RESET     32'h0000_0000
`define DMI_FUNC_RESET     32'h0000_0000
`define DMI_MAXFREQ_RESET  16'hFFFF
`define DMI_FRAC_FULL      9'h100
`define DMI_TIMER_MAX      12'hBB8

// ----------------------------------------------------------------------
// Input function codes
// ----------------------------------------------------------------------
`define DMI_FN_UP       8'h10
`define DMI_FN_DOWN     8'h11
`define DMI_FN_JOGFWD   8'h12
`define DMI_FN_JOGREV   8'h13
`define DMI_FN_FLTRST   8'h14
`define DMI_FN_FSTOP    8'h15
`define DMI_FN_MOTOR2   8'h16
`define DMI_FN_FSTOP2   8'h17
`define DMI_FN_TIMER    8'h18
`define DMI_FN_LOCK     8'h1B
`define DMI_FN_TRIMUP   8'h1C
`define DMI_FN_TRIMDN   8'h1D
`define DMI_FN_SAMPLE   8'h1E
`define DMI_FN_ANASEL   8'h1F
`define DMI_FN_EXTF_HI  4'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DMI_CLK_HZ       100000000
`define DMI_MS_PER_S     1000
`define DMI_TICK_CYCLES  (`DMI_CLK_HZ / `DMI_MS_PER_S)
`define DMI_JOG_CONF_MS  10'd500
`define DMI_SAMPLE_MS    7'd100
`define DMI_TENTH_MS     19'd100

`endif

// [include/dmi_pkg.sv]
// Types shared by the multi-function input logic.
package dmi_pkg;
  `include "dmi_regs.svh"

  typedef enum logic [1:0] {
    DMI_JOG_IDLE,
    DMI_JOG_BOTH,
    DMI_JOG_HALT
  } dmi_jog_e;

  typedef struct packed {
    logic [9:0]  meta;
    logic [9:0]  pins;
    logic [16:0] tickCnt;
    logic        msTick;
    logic [31:0] funcLo;
    logic [31:0] funcHi;
    logic [31:0] ctrl;
    logic [15:0] maxFreq;
    logic [8:0]  upperFrac;
    logic [15:0] lowerLimit;
    logic [15:0] jogRef;
    logic [15:0] trimLevel;
    logic [11:0] onDelay;
    logic [11:0] offDelay;
    logic [15:0] updnRef;
    dmi_jog_e    jogState;
    logic [9:0]  jogMs;
    logic [6:0]  shMs;
    logic        shDone;
    logic        shHeld;
    logic [15:0] shValue;
    logic [18:0] timerMs;
    logic        timerOut;
    logic        runInhibit;
    logic [15:0] freqRef;
    logic        runFwd;
    logic        runRev;
    logic        rampStop;
    logic        coastStop;
    logic        fastStop;
    logic        motor2;
    logic        faultReset;
    logic        paramLock;
    logic        cfgError;
    logic        extFault;
    logic [1:0]  extAction;
    logic        waitReq;
    logic [31:0] readData;
  } dmi_state_s;
endpackage : dmi_pkg

// [design/dmi_input_logic.sv]
// Multi-function contact input interpreter with Avalon-MM registers.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "dmi_regs.svh"

module dmi_input_logic #(
  parameter int TICK_CYCLES = `DMI_TICK_CYCLES
) (
  // Clock and reset.
  input  logic        sys_clk,
  input  logic        rst_n,
  // Avalon-MM slave.
  input  logic [7:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  // Contact pins.
  input  logic [7:0]  contactIn,
  input  logic        runFwdPin,
  input  logic        runRevPin,
  // Drive status and analog values on this clock.
  input  logic        driveRunning,
  input  logic        driveStopped,
  input  logic        faultPresent,
  input  logic [15:0] analogPrimary,
  input  logic [15:0] analogSecondary,
  // Commands to the drive.
  output logic [15:0] freqRef,
  output logic        runFwd,
  output logic        runRev,
  output logic        rampStop,
  output logic        coastStop,
  output logic        fastStop,
  output logic        motor2Select,
  output logic        faultReset,
  output logic        paramLock,
  output logic        inputConfigError,
  output logic        extFault,
  output logic [1:0]  extAction,
  output logic        timerOut
);
  import dmi_pkg::*;

  dmi_state_s st;
  dmi_state_s next_st;

  // --------------------------------------------------------------------
  // Contact decoding
  // --------------------------------------------------------------------

  // True when some input carries the code and, if wanted, is closed.
  function automatic logic fnHit(input logic [63:0] codes,
                                 input logic [7:0]  pins,
                                 input logic [7:0]  code,
                                 input logic        needClosed);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (codes[i*8 +: 8] == code && (pins[i] || !needClosed)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : fnHit

  logic [63:0] codes;
  logic [7:0]  pins;
  logic        upIn, dnIn, jogFwdIn, jogRevIn, fltRstIn, fStopIn;
  logic        fStop2In, mot2In, timerIn, lockClosed, lockUsed;
  logic        trimUpIn, trimDnIn, sampleIn, anaSelIn, anaSelUsed;
  logic        runCmd, updnEn, jogActive;
  logic [15:0] masterAna, analogRef, lowerClamp, upperClamp, baseRef;
  logic [24:0] upperProd;
  logic [16:0] trimSum;
  logic [18:0] onLimit, offLimit;

  assign codes = {st.funcHi, st.funcLo};
  assign pins  = st.pins[7:0];

  // Contact functions are closed-contact tests over all inputs, except lockUsed and anaSelUsed, which only look for the code.
  assign upIn       = fnHit(codes, pins, `DMI_FN_UP, 1'b1);
  assign dnIn       = fnHit(codes, pins, `DMI_FN_DOWN, 1'b1);
  assign jogFwdIn   = fnHit(codes, pins, `DMI_FN_JOGFWD, 1'b1);
  assign jogRevIn   = fnHit(codes, pins, `DMI_FN_JOGREV, 1'b1);
  assign fltRstIn   = fnHit(codes, pins, `DMI_FN_FLTRST, 1'b1);
  assign fStopIn    = fnHit(codes, pins, `DMI_FN_FSTOP, 1'b1);
  assign fStop2In   = fnHit(codes, pins, `DMI_FN_FSTOP2, 1'b1);
  assign mot2In     = fnHit(codes, pins, `DMI_FN_MOTOR2, 1'b1);
  assign timerIn    = fnHit(codes, pins, `DMI_FN_TIMER, 1'b1);
  assign lockClosed = fnHit(codes, pins, `DMI_FN_LOCK, 1'b1);
  assign lockUsed   = fnHit(codes, pins, `DMI_FN_LOCK, 1'b0);
  assign trimUpIn   = fnHit(codes, pins, `DMI_FN_TRIMUP, 1'b1);
  assign trimDnIn   = fnHit(codes, pins, `DMI_FN_TRIMDN, 1'b1);
  assign sampleIn   = fnHit(codes, pins, `DMI_FN_SAMPLE, 1'b1);
  assign anaSelIn   = fnHit(codes, pins, `DMI_FN_ANASEL, 1'b1);
  assign anaSelUsed = fnHit(codes, pins, `DMI_FN_ANASEL, 1'b0);

  // --------------------------------------------------------------------
  // Reference path
  // --------------------------------------------------------------------

  // Master analog source and its optional sampled copy.
  assign masterAna = anaSelIn ? analogSecondary : analogPrimary;
  assign analogRef = st.shHeld ? st.shValue : masterAna;

  // Limits used while up/down moves the reference.
  assign upperProd  = st.maxFreq * {7'h00, st.upperFrac};
  assign upperClamp = st.ctrl[`DMI_CTRL_UPLIMUSE] ?
                      upperProd[23:8] : st.maxFreq;
  assign lowerClamp = (masterAna > st.lowerLimit) ?
                      masterAna : st.lowerLimit;

  assign runCmd    = st.pins[8] | st.pins[9];
  assign updnEn    = st.ctrl[`DMI_CTRL_REFSEL];
  assign jogActive = jogFwdIn | jogRevIn;
  assign baseRef   = jogActive ? st.jogRef :
                     (updnEn ? st.updnRef : analogRef);

  // Saturating trim, only with REFSEL set; reference source zero is the analog input.
  always_comb begin
    trimSum = {1'b0, baseRef};
    if (st.ctrl[`DMI_CTRL_REFSEL] && trimUpIn && !trimDnIn) begin
      trimSum = {1'b0, baseRef} + {1'b0, st.trimLevel};
      if (trimSum[16]) begin
        trimSum = 17'h0FFFF;
      end
    end else if (st.ctrl[`DMI_CTRL_REFSEL] && trimDnIn && !trimUpIn) begin
      trimSum = (baseRef > st.trimLevel) ?
                {1'b0, baseRef - st.trimLevel} : 17'h00000;
    end
  end

  // Timer thresholds in milliseconds from tenths of a second.
  assign onLimit  = {7'h00, st.onDelay} * `DMI_TENTH_MS;
  assign offLimit = {7'h00, st.offDelay} * `DMI_TENTH_MS;

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------

  // All behaviour updates the one state copy; the bus slave is last.
  always_comb begin
    next_st = st;
    // Two flops per pin before any logic looks at a contact.
    next_st.meta = {runRevPin, runFwdPin, contactIn};
    next_st.pins = st.meta;

    // Millisecond tick shared by every duration measurement.
    if (st.tickCnt == 17'(TICK_CYCLES - 1)) begin
      next_st.tickCnt = 17'h00000;
      next_st.msTick  = 1'b1;
    end else begin
      next_st.tickCnt = st.tickCnt + 17'h00001;
      next_st.msTick  = 1'b0;
    end

    // Up/down ramps one unit per millisecond; neither or both holds.
    if (updnEn && runCmd && st.msTick) begin
      if (upIn && !dnIn) begin
        next_st.updnRef = (st.updnRef >= upperClamp) ?
                          upperClamp : st.updnRef + 16'h0001;
      end else if (dnIn && !upIn) begin
        next_st.updnRef = (st.updnRef <= lowerClamp) ?
                          lowerClamp : st.updnRef - 16'h0001;
      end
    end

    // Conflicting jog contacts: time the overlap, then stop.
    case (st.jogState)
      DMI_JOG_IDLE: begin
        next_st.jogMs = 10'h000;
        if (jogFwdIn && jogRevIn) begin
          next_st.jogState = DMI_JOG_BOTH;
        end
      end
      DMI_JOG_BOTH: begin
        if (!(jogFwdIn && jogRevIn)) begin
          next_st.jogState = DMI_JOG_IDLE;
        end else if (st.msTick) begin
          next_st.jogMs = st.jogMs + 10'h001;
          if (st.jogMs >= `DMI_JOG_CONF_MS) begin
            next_st.jogState = DMI_JOG_HALT;
          end
        end
      end
      DMI_JOG_HALT: begin
        if (!(jogFwdIn && jogRevIn)) begin
          next_st.jogState = DMI_JOG_IDLE;
        end
      end
      default: next_st.jogState = DMI_JOG_IDLE;
    endcase

    // Fast-stop inhibit is released only with all run sources open.
    if (fStopIn) begin
      next_st.runInhibit = 1'b1;
    end else if (!runCmd && !jogActive) begin
      next_st.runInhibit = 1'b0;
    end

    // Run direction: jog first, then normal run, forward wins a tie.
    next_st.runFwd = 1'b0;
    next_st.runRev = 1'b0;
    if (!st.runInhibit && !fStopIn && st.jogState != DMI_JOG_HALT) begin
      if (jogFwdIn) begin
        next_st.runFwd = 1'b1;
      end else if (jogRevIn) begin
        next_st.runRev = 1'b1;
      end else begin
        next_st.runFwd = st.pins[8];
        next_st.runRev = st.pins[9] & ~st.pins[8];
      end
    end
    next_st.rampStop  = (st.jogState == DMI_JOG_HALT) &&
                        !st.ctrl[`DMI_CTRL_STOPCOAST];
    next_st.coastStop = (st.jogState == DMI_JOG_HALT) &&
                        st.ctrl[`DMI_CTRL_STOPCOAST];
    next_st.fastStop  = fStopIn | fStop2In;
    next_st.freqRef   = trimSum[15:0];

    // Motor set follows the contact only while the drive is stopped.
    if (driveStopped) begin
      next_st.motor2 = mot2In;
    end
    next_st.faultReset = fltRstIn && !faultPresent;
    next_st.paramLock  = lockUsed && !lockClosed;
    next_st.cfgError   = anaSelUsed &&
      (st.ctrl[`DMI_CTRL_SECFN_LSB +: 8] != `DMI_FN_ANASEL);

    // Sample once after a 100 ms closure; short closures do nothing.
    if (!sampleIn) begin
      next_st.shMs   = 7'h00;
      next_st.shDone = 1'b0;
    end else if (!st.shDone && st.msTick) begin
      next_st.shMs = st.shMs + 7'h01;
      if (st.shMs + 7'h01 >= `DMI_SAMPLE_MS) begin
        next_st.shDone  = 1'b1;
        next_st.shHeld  = 1'b1;
        next_st.shValue = masterAna;
      end
    end

    // Independent timer: output flips after a long enough new level.
    if (timerIn == st.timerOut) begin
      next_st.timerMs = 19'h00000;
    end else if (st.msTick) begin
      next_st.timerMs = st.timerMs + 19'h00001;
      if (st.timerMs >= (timerIn ? onLimit : offLimit)) begin
        next_st.timerOut = timerIn;
        next_st.timerMs  = 19'h00000;
      end
    end

    // External fault: lowest numbered input wins; polarity, gate, act.
    next_st.extFault  = 1'b0;
    next_st.extAction = 2'h0;
    for (int i = 7; i >= 0; i--) begin
      if (codes[i*8+4 +: 4] == `DMI_FN_EXTF_HI &&
          (pins[i] ^ codes[i*8]) &&
          (driveRunning || !codes[i*8+1])) begin
        next_st.extFault  = 1'b1;
        next_st.extAction = codes[i*8+2 +: 2];
      end
    end

    // Avalon slave: answer one cycle after the request is seen.
    next_st.waitReq = 1'b1;
    if ((avs_read || avs_write) && st.waitReq) begin
      next_st.waitReq  = 1'b0;
      next_st.readData = 32'h0000_0000;
      if (avs_write && !st.paramLock) begin
        if (avs_address == `DMI_OFS_FUNC_LO) begin
          next_st.funcLo = avs_writedata;
        end else if (avs_address == `DMI_OFS_FUNC_HI) begin
          next_st.funcHi = avs_writedata;
        end else if (avs_address == `DMI_OFS_CTRL) begin
          next_st.ctrl = avs_writedata & 32'h0000_FF0F;
        end else if (avs_address == `DMI_OFS_MAXFREQ) begin
          next_st.maxFreq = avs_writedata[15:0];
        end else if (avs_address == `DMI_OFS_LIMITS) begin
          next_st.upperFrac = (avs_writedata[8:0] > `DMI_FRAC_FULL) ?
                              `DMI_FRAC_FULL : avs_writedata[8:0];
          next_st.lowerLimit = avs_writedata[31:16];
        end else if (avs_address == `DMI_OFS_JOGREF) begin
          next_st.jogRef = avs_writedata[15:0];
        end else if (avs_address == `DMI_OFS_TRIM) begin
          next_st.trimLevel = avs_writedata[15:0];
        end else if (avs_address == `DMI_OFS_TIMER) begin
          next_st.onDelay = (avs_writedata[11:0] > `DMI_TIMER_MAX) ?
                            `DMI_TIMER_MAX : avs_writedata[11:0];
          next_st.offDelay = (avs_writedata[27:16] > `DMI_TIMER_MAX) ?
                             `DMI_TIMER_MAX : avs_writedata[27:16];
        end else if (avs_address == `DMI_OFS_HOLD &&
                     st.ctrl[`DMI_CTRL_HOLDMEM]) begin
          next_st.updnRef = avs_writedata[15:0];
        end
      end else if (avs_read) begin
        if (avs_address == `DMI_OFS_FUNC_LO) begin
          next_st.readData = st.funcLo;
        end else if (avs_address == `DMI_OFS_FUNC_HI) begin
          next_st.readData = st.funcHi;
        end else if (avs_address == `DMI_OFS_CTRL) begin
          next_st.readData = st.ctrl;
        end else if (avs_address == `DMI_OFS_MAXFREQ) begin
          next_st.readData = {16'h0000, st.maxFreq};
        end else if (avs_address == `DMI_OFS_LIMITS) begin
          next_st.readData = {st.lowerLimit, 7'h00, st.upperFrac};
        end else if (avs_address == `DMI_OFS_JOGREF) begin
          next_st.readData = {16'h0000, st.jogRef};
        end else if (avs_address == `DMI_OFS_TRIM) begin
          next_st.readData = {16'h0000, st.trimLevel};
        end else if (avs_address == `DMI_OFS_TIMER) begin
          next_st.readData = {4'h0, st.offDelay, 4'h0, st.onDelay};
        end else if (avs_address == `DMI_OFS_HOLD) begin
          next_st.readData = st.ctrl[`DMI_CTRL_HOLDMEM] ?
                             {16'h0000, st.updnRef} : 32'h0000_0000;
        end else if (avs_address == `DMI_OFS_STATUS) begin
          next_st.readData = {16'h0000, st.pins[7:0], st.extAction,
                              st.extFault, st.cfgError, st.paramLock,
                              st.timerOut, st.motor2, st.runInhibit};
        end else if (avs_address == `DMI_OFS_FREQ) begin
          next_st.readData = {st.updnRef, st.freqRef};
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------

  // Synchronous reset loads constants only; hold value comes by bus.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st           <= '0;
      st.funcLo    <= `DMI_FUNC_RESET;
      st.funcHi    <= `DMI_FUNC_RESET;
      st.ctrl      <= `DMI_CTRL_RESET;
      st.maxFreq   <= `DMI_MAXFREQ_RESET;
      st.upperFrac <= `DMI_FRAC_FULL;
      st.jogState  <= DMI_JOG_IDLE;
      st.waitReq   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flops.
  assign avs_readdata     = st.readData;
  assign avs_waitrequest  = st.waitReq;
  assign freqRef          = st.freqRef;
  assign runFwd           = st.runFwd;
  assign runRev           = st.runRev;
  assign rampStop         = st.rampStop;
  assign coastStop        = st.coastStop;
  assign fastStop         = st.fastStop;
  assign motor2Select     = st.motor2;
  assign faultReset       = st.faultReset;
  assign paramLock        = st.paramLock;
  assign inputConfigError = st.cfgError;
  assign extFault         = st.extFault;
  assign extAction        = st.extAction;
  assign timerOut         = st.timerOut;
endmodule : dmi_input_logic

// [dv/dmi_contact_model.sv]
// Contact and switch model that feeds the multi-function inputs.
`timescale 1ns/1ps
module dmi_contact_model (
  // Clock.
  input  logic       sys_clk,
  // Wanted contact states: [7:0] inputs, [8] forward, [9] reverse.
  input  logic [9:0] want,
  // Contact pins, closed is 1.
  output logic [7:0] contactIn = 8'h00,
  output logic       runFwdPin = 1'b0,
  output logic       runRevPin = 1'b0
);
  // Contacts move just after an edge; bounce is left out, so the bench
  // cannot show how the synchroniser copes with chatter.
  always @(posedge sys_clk) begin
    {runRevPin, runFwdPin, contactIn} <= want;
  end
endmodule : dmi_contact_model

// [dv/dmi_input_logic_chk.sv]
// Concurrent checks on the ports of the input interpreter.
`timescale 1ns/1ps
module dmi_input_chk (
  // Clock and reset.
  input logic        sys_clk,
  input logic        rst_n,
  // Bus and status.
  input logic        avs_read,
  input logic        avs_write,
  input logic        avs_waitrequest,
  input logic        faultPresent,
  // Commands.
  input logic [15:0] freqRef,
  input logic        runFwd,
  input logic        runRev,
  input logic        rampStop,
  input logic        coastStop,
  input logic        fastStop,
  input logic        faultReset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  chk_wait_answer: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("no bus answer");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_cause: assert property ($fell(avs_waitrequest) |->
    $past(avs_read || avs_write)) else $error("answer without request");
  chk_reset_vals: assert property ($rose(rst_n) |-> freqRef == 16'h0000 &&
    !runFwd && !runRev && avs_waitrequest) else $error("bad reset state");
  chk_fault_gate: assert property (faultPresent [*2] |=> !faultReset)
    else $error("fault reset while fault present");
  chk_fstop_norun: assert property (fastStop [*3] |-> !runFwd && !runRev)
    else $error("run during fast stop");
  chk_jog_halt: assert property ($rose(rampStop || coastStop) |->
    ##[0:2] (!runFwd && !runRev)) else $error("run kept after jog halt");
  chk_run_excl: assert property (!(runFwd && runRev))
    else $error("both directions commanded");
  chk_stop_excl: assert property (!(rampStop && coastStop))
    else $error("two stop methods at once");
  // Main scenarios reached.
  cov_halt: cover property ($rose(rampStop));
  cov_fstop: cover property (fastStop && !runFwd);
  cov_freset: cover property ($rose(faultReset));
endmodule : dmi_input_chk

bind dmi_input_logic dmi_input_chk chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .faultPresent(faultPresent),
  .freqRef(freqRef), .runFwd(runFwd), .runRev(runRev),
  .rampStop(rampStop), .coastStop(coastStop), .fastStop(fastStop),
  .faultReset(faultReset));

// [dv/tb.sv]
// Self-checking bench for the multi-function input interpreter.
`timescale 1ns/1ps
`include "dmi_regs.svh"
module tb;
  logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, contactIn;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        runFwdPin, runRevPin, faultPresent, runFwd, runRev;
  logic        rampStop, fastStop, faultReset, paramLock, cfgErr;
  logic        coastStop, motor2Select, extFault, timerOut;
  logic        driveRunning, driveStopped;
  logic [1:0]  extAction;
  logic [15:0] analogPrimary, freqRef, analogSecondary;
  logic [9:0]  want;
  int          errorCnt, checkCount;
  // Bench drives every input from time zero; 1 ms is 10 cycles here.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, avs_read, avs_write, faultPresent} = 4'h0;
    {driveRunning, driveStopped} = 2'b01;
    {avs_address, avs_writedata, analogPrimary, analogSecondary} = '0;
    want = 10'h040;
    errorCnt = 0;
    checkCount = 0;
  end
  dmi_contact_model dmi_contact_model_i (.sys_clk(sys_clk), .want(want),
    .contactIn(contactIn), .runFwdPin(runFwdPin), .runRevPin(runRevPin));
  dmi_input_logic #(.TICK_CYCLES(10)) dmi_input_logic_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .contactIn(contactIn),
    .runFwdPin(runFwdPin), .runRevPin(runRevPin),
    .driveRunning(driveRunning), .driveStopped(driveStopped),
    .faultPresent(faultPresent), .analogPrimary(analogPrimary),
    .analogSecondary(analogSecondary),
    .freqRef(freqRef), .runFwd(runFwd), .runRev(runRev),
    .rampStop(rampStop), .coastStop(coastStop), .fastStop(fastStop),
    .motor2Select(motor2Select), .faultReset(faultReset),
    .paramLock(paramLock), .inputConfigError(cfgErr),
    .extFault(extFault), .extAction(extAction), .timerOut(timerOut));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task reportAndStop;
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : reportAndStop
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : w
  // One Avalon transfer; request held until waitrequest is seen low.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      errorCnt++;
      reportAndStop();
    end
  endtask : bus
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task tRegs;
    bus(1'b0, `DMI_OFS_MAXFREQ, 32'h0);
    check(q, 32'h0000_FFFF);
    bus(1'b0, `DMI_OFS_LIMITS, 32'h0);
    check(q, 32'h0000_0100);
    bus(1'b0, 8'h40, 32'h0);
    check(q, 32'h0000_0000);
    bus(1'b1, `DMI_OFS_CTRL, 32'hFFFF_FFFF);
    bus(1'b0, `DMI_OFS_CTRL, 32'h0);
    check(q, 32'h0000_FF0F);
    bus(1'b1, `DMI_OFS_FUNC_LO, 32'h1312_1110);
    bus(1'b1, `DMI_OFS_FUNC_HI, 32'h1F1B_1415);
    bus(1'b1, `DMI_OFS_MAXFREQ, 32'h0000_0064);
    bus(1'b1, `DMI_OFS_LIMITS, 32'h0010_0080);
    bus(1'b1, `DMI_OFS_JOGREF, 32'h0000_0020);
    bus(1'b1, `DMI_OFS_CTRL, 32'h0000_0008);
    w(3);
    check(cfgErr, 1'b1);
    $display("registers done");
  endtask : tRegs
  task tUpDown;
    want <= 10'h141;
    w(300);
    bus(1'b0, `DMI_OFS_FREQ, 32'h0);
    check(q[31:16], 16'h0000);
    bus(1'b1, `DMI_OFS_CTRL, 32'h0000_1F09);
    w(800);
    check(cfgErr, 1'b0);
    bus(1'b0, `DMI_OFS_FREQ, 32'h0);
    check(q[31:16], 16'h0032);
    analogPrimary <= 16'h0008;
    want <= 10'h142;
    w(600);
    bus(1'b0, `DMI_OFS_FREQ, 32'h0);
    check(q[31:16], 16'h0010);
    bus(1'b0, `DMI_OFS_HOLD, 32'h0);
    check(q, 32'h0000_0000);
    want <= 10'h040;
    w(6);
    $display("up down done");
  endtask : tUpDown
  task tJog;
    int n;
    want <= 10'h244;
    w(6);
    check({runFwd, runRev, freqRef}, {2'b10, 16'h0020});
    want <= 10'h04C;
    w(4500);
    check(rampStop, 1'b0);
    for (n = 0; n < 1000 && rampStop !== 1'b1; n++) @(posedge sys_clk);
    if (n == 1000) begin
      errorCnt++;
      reportAndStop();
    end
    w(3);
    check({rampStop, coastStop, runFwd, runRev}, 4'b1000);
    want <= 10'h040;
    w(6);
    $display("jog done");
  endtask : tJog
  task tFstop;
    want <= 10'h150;
    w(6);
    check({fastStop, runFwd}, 2'b10);
    want <= 10'h140;
    w(6);
    check(runFwd, 1'b0);
    want <= 10'h040;
    w(6);
    want <= 10'h140;
    w(6);
    check(runFwd, 1'b1);
    faultPresent <= 1'b1;
    want <= 10'h060;
    w(6);
    check(faultReset, 1'b0);
    faultPresent <= 1'b0;
    w(4);
    check(faultReset, 1'b1);
    $display("fast stop done");
  endtask : tFstop
  task tLock;
    want <= 10'h000;
    w(6);
    check(paramLock, 1'b1);
    bus(1'b1, `DMI_OFS_JOGREF, 32'h0000_0055);
    bus(1'b0, `DMI_OFS_JOGREF, 32'h0);
    check(q, 32'h0000_0020);
    want <= 10'h040;
    w(6);
    bus(1'b1, `DMI_OFS_JOGREF, 32'h0000_0055);
    bus(1'b0, `DMI_OFS_JOGREF, 32'h0);
    check(q, 32'h0000_0055);
    $display("lockout done");
  endtask : tLock
  // Motor set, timer, external fault, trim, sample/hold and analog select.
  task tPins;
    bus(1'b1, `DMI_OFS_FUNC_LO, 32'h261E_1816);
    bus(1'b1, `DMI_OFS_FUNC_HI, 32'h1F1B_1C15);
    bus(1'b1, `DMI_OFS_TRIM, 32'h0000_0005);
    bus(1'b1, `DMI_OFS_TIMER, 32'h0000_0001);
    {driveRunning, driveStopped} <= 2'b10;
    analogSecondary <= 16'h0077;
    want <= 10'h0EF;
    w(600);
    check({motor2Select, timerOut}, 2'b00);
    check({extFault, extAction}, 3'b101);
    check(freqRef, 16'h0015);
    {driveRunning, driveStopped} <= 2'b01;
    w(600);
    check({motor2Select, timerOut, extFault}, 3'b110);
    bus(1'b1, `DMI_OFS_CTRL, 32'h0000_1F0A);
    analogSecondary <= 16'h0099;
    bus(1'b0, `DMI_OFS_HOLD, 32'h0);
    check(q, 32'h0000_0010);
    check(freqRef, 16'h0077);
    $display("contact functions done");
  endtask : tPins
  // Main sequence.
  initial begin
    w(3);
    rst_n <= 1'b1;
    tRegs();
    tUpDown();
    tJog();
    tFstop();
    tLock();
    tPins();
    reportAndStop();
  end
endmodule : tb
